// File: design/slcp_consts.vh
`ifndef SLCP_CONSTS_VH
`define SLCP_CONSTS_VH
// Register map, byte addresses
`define SLCP_A_CFG     8'h00
`define SLCP_A_STAT    8'h04
`define SLCP_A_LAST    8'h08
// Configuration word
`define SLCP_WORD_W    14
`define SLCP_CFG_DEF   14'h0358
`define SLCP_OFF_BIT   1
`define SLCP_LIM_LSB   0
`define SLCP_BAUD_LSB  12
`define SLCP_LIM_MIN   6'h0c
`define SLCP_LIM_DEF   6'h18
// Start pulse classes in basic clock periods
`define SLCP_T1_MIN    16'h0010
`define SLCP_T1_SHORT  16'h05ff
`define SLCP_T1_LONG   16'h1600
// Sequence timing in basic clock periods, then the divider in system clocks per period
`define SLCP_T2        16'h0010
`define SLCP_T3        16'h0008
`define SLCP_T4        16'h0004
`define SLCP_T5        16'h0010
`define SLCP_T6        16'h0030
`define SLCP_T7_MIN    16'h0002
`define SLCP_T8        16'h0008
`define SLCP_T9        16'h0030
`define SLCP_TRST      16'h0100
`define SLCP_RM_HALF   16'h0200
`define SLCP_CLK_DIV   8'h32
`endif

// File: design/slcp_tick.v
`timescale 1ns/100ps
`include "slcp_consts.vh"
// Basic clock period strobe from the system clock
module slcp_tick #(
  parameter [7:0] DIV = `SLCP_CLK_DIV
) (
  // Clock and reset
  input  wire       i_clk_sys,
  input  wire       i_srst,
  // Strobe
  output reg        o_tick
);
  reg [7:0] cnt;

  // Divider, one tick per basic period
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      cnt    <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt == DIV - 8'h01) begin
      cnt    <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule // slcp_tick

// File: design/slcp_marker.v
`timescale 1ns/100ps
`include "slcp_consts.vh"
// Reset marker square wave, half period counted in ticks
module slcp_marker #(
  parameter [15:0] HALF = `SLCP_RM_HALF
) (
  // Clock and reset
  input  wire       i_clk_sys,
  input  wire       i_srst,
  // Control
  input  wire       i_tick,
  input  wire       i_run,
  // Wave, high means line pulled low
  output reg        o_low
);
  reg [15:0] cnt;

  // Equal halves give the 50 percent duty; kept slow so it never looks like data
  always @(posedge i_clk_sys) begin
    if (i_srst || !i_run) begin
      cnt   <= 16'h0000;
      o_low <= 1'b0;
    end else if (i_tick) begin
      if (cnt == HALF - 16'h0001) begin
        cnt   <= 16'h0000;
        o_low <= ~o_low;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // slcp_marker

// File: design/slcp_core.v
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "slcp_consts.vh"
module slcp_core #(
  parameter [7:0]  CLK_DIV = `SLCP_CLK_DIV,
  parameter [15:0] T_RST   = `SLCP_TRST,
  parameter [15:0] RM_HALF = `SLCP_RM_HALF
) (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_srst,
  // Power-on reset request from supply monitor
  input  wire        i_por,
  // Receiver state
  input  wire        i_rx_active,
  // Data line
  input  wire        i_data,
  output reg         o_data_oe,
  output reg         o_data_o,
  // Register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Configuration and control outputs
  output reg  [13:0] o_cfg,
  output reg  [5:0]  o_lim_max,
  output reg  [3:0]  o_limit_extension_factor,
  output reg         o_rx_disable,
  output reg         o_off_cmd,
  output reg         o_in_reset
);
  // Sequencer states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LOW  = 3'h1;
  localparam [2:0] S_DLY  = 3'h2;
  localparam [2:0] S_BIT  = 3'h3;
  localparam [2:0] S_EQ   = 3'h4;
  // Frame landmarks: last bit index, and window bounds in ticks as fixed sums of the timing constants
  localparam integer LAST_BIT = `SLCP_WORD_W - 1;
  localparam [15:0]  WIN_OPEN = `SLCP_T3 + `SLCP_T4;
  localparam [15:0]  WIN_SHUT = `SLCP_T3 + `SLCP_T4 + `SLCP_T5;

  // Sequencer and reset bookkeeping
  wire        tick;
  wire        rm_low;
  reg  [2:0]  state;
  reg  [15:0] tcnt;
  reg  [15:0] lcnt;
  reg  [3:0]  bitn;
  reg  [13:0] shreg;
  reg         seen_zero;
  reg         por_hold;
  reg  [15:0] rcnt;
  reg         reset_mode;
  reg         eq_flag;
  reg  [2:0]  seq_count;
  reg         next_drive;
  wire        marker_run;
  wire        host_pull;
  wire        in_window;
  wire [13:0] next_word;

  // Marker rests during the reset stretch and while a sequence owns the line
  assign marker_run = reset_mode && !por_hold && (state == S_IDLE);
  // Own drive is registered and lags a cycle, so mask it or a marker release reads as a start
  assign host_pull  = !i_data && !o_data_oe;
  // Sampling window of the current bit frame
  assign in_window  = (tcnt >= WIN_OPEN) && (tcnt < WIN_SHUT);
  // Word as it stands once the current bit is shifted in
  assign next_word  = {shreg[12:0], ~seen_zero};

  // Extension factor from the baud range field
  function [3:0] limit_extension_factor;
    input [1:0] br;
    begin
      case (br)
        2'b00:   limit_extension_factor = 4'h8;
        2'b01:   limit_extension_factor = 4'h4;
        2'b10:   limit_extension_factor = 4'h2;
        default: limit_extension_factor = 4'h1;
      endcase
    end
  endfunction

  // Invalid limit codes fall back to default so the checker never sees them
  function [5:0] lim_ok;
    input [5:0] code;
    begin
      lim_ok = (code < `SLCP_LIM_MIN) ? `SLCP_LIM_DEF : code;
    end
  endfunction

  // One basic period strobe shared by every counter
  slcp_tick #(
    .DIV(CLK_DIV)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_srst   (i_srst),
    .o_tick   (tick)
  );

  // Reset marker generator
  slcp_marker #(
    .HALF(RM_HALF)
  ) u_marker (
    .i_clk_sys(i_clk_sys),
    .i_srst   (i_srst),
    .i_tick   (tick),
    .i_run    (marker_run),
    .o_low    (rm_low)
  );

  // Power-on reset stretch after the supply comes back
  always @(posedge i_clk_sys) begin
    if (i_srst || i_por) begin
      por_hold <= 1'b1;
      rcnt     <= 16'h0000;
    end else if (por_hold && tick) begin
      if (rcnt == T_RST - 16'h0001) begin
        por_hold <= 1'b0;
      end else begin
        rcnt <= rcnt + 16'h0001;
      end
    end
  end

  // Sequencer; runs regardless of i_rx_active since sleep and active both accept it
  always @(posedge i_clk_sys) begin
    if (i_srst || por_hold) begin
      state      <= S_IDLE;
      tcnt       <= 16'h0000;
      lcnt       <= 16'h0000;
      bitn       <= 4'h0;
      shreg      <= 14'h0000;
      seen_zero  <= 1'b0;
      reset_mode <= 1'b1;
      o_cfg      <= `SLCP_CFG_DEF;
      eq_flag    <= 1'b0;
      o_off_cmd  <= 1'b0;
      seq_count  <= 3'h0;
      next_drive <= 1'b0;
    end else begin
      o_off_cmd <= 1'b0;
      if (i_wr && i_addr == `SLCP_A_CFG) begin
        o_cfg <= i_wdata[13:0];
      end
      case (state)
        S_IDLE: begin
          tcnt <= 16'h0000;
          if (host_pull && !rm_low) begin
            state <= S_LOW;
          end
        end
        S_LOW: begin
          if (tick && tcnt != 16'hffff) begin
            tcnt <= tcnt + 16'h0001;
          end
          if (i_data) begin
            if (tcnt > `SLCP_T1_LONG) begin
              reset_mode <= 1'b0;
              state      <= S_DLY;
              tcnt       <= 16'h0000;
            end else if (tcnt > `SLCP_T1_MIN && tcnt < `SLCP_T1_SHORT && !reset_mode) begin
              state <= S_DLY;
              tcnt  <= 16'h0000;
            end else begin
              state <= S_IDLE;
            end
            bitn <= 4'h0;
          end
        end
        S_DLY: begin
          if (tick) begin
            if (tcnt == `SLCP_T2 - 16'h0001) begin
              state     <= S_BIT;
              tcnt      <= 16'h0000;
              seen_zero <= 1'b0;
              lcnt      <= 16'h0000;
            end else begin
              tcnt <= tcnt + 16'h0001;
            end
          end
        end
        S_BIT: begin
          // Sync pulse at the head of each bit frame
          next_drive <= (tcnt < `SLCP_T3);
          if (tick) begin
            // Window sampling: host low long enough means zero
            if (in_window) begin
              if (!i_data) begin
                lcnt <= lcnt + 16'h0001;
                if (lcnt + 16'h0001 >= `SLCP_T7_MIN) begin
                  seen_zero <= 1'b1;
                end
              end else begin
                lcnt <= 16'h0000;
              end
            end
            if (tcnt == `SLCP_T6 - 16'h0001) begin
              shreg     <= next_word;
              seen_zero <= 1'b0;
              lcnt      <= 16'h0000;
              tcnt      <= 16'h0000;
              if (bitn == LAST_BIT[3:0]) begin
                state   <= S_EQ;
                eq_flag <= (next_word == o_cfg);
              end else begin
                bitn <= bitn + 4'h1;
              end
            end else begin
              tcnt <= tcnt + 16'h0001;
            end
          end
        end
        S_EQ: begin
          next_drive <= eq_flag && (tcnt < `SLCP_T8);
          if (tick) begin
            if (tcnt == `SLCP_T9 - 16'h0001) begin
              state      <= S_IDLE;
              next_drive <= 1'b0;
              o_cfg      <= shreg;
              o_off_cmd  <= shreg[`SLCP_OFF_BIT];
              if (seq_count != 3'h7) begin
                seq_count <= seq_count + 3'h1;
              end
            end else begin
              tcnt <= tcnt + 16'h0001;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Open-drain line: only ever pulled low, pull-up gives the high level
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_data_oe <= 1'b0;
      o_data_o  <= 1'b0;
    end else begin
      o_data_oe <= next_drive && (state == S_BIT || state == S_EQ) || rm_low;
      o_data_o  <= 1'b0;
    end
  end

  // Derived configuration views and status
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_lim_max                <= `SLCP_LIM_DEF;
      o_limit_extension_factor <= 4'h8;
      o_rx_disable             <= 1'b0;
      o_in_reset               <= 1'b1;
    end else begin
      o_lim_max                <= lim_ok(o_cfg[`SLCP_LIM_LSB +: 6]);
      o_limit_extension_factor <= limit_extension_factor(o_cfg[`SLCP_BAUD_LSB +: 2]);
      o_rx_disable             <= (state == S_DLY || state == S_BIT || state == S_EQ);
      o_in_reset               <= reset_mode || por_hold;
    end
  end

  // Register read port, answer in the next cycle only
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `SLCP_A_CFG:  o_rdata <= {18'h0, o_cfg};
        `SLCP_A_STAT: o_rdata <= {24'h000000, seq_count, i_rx_active, eq_flag, o_rx_disable,
                                  reset_mode, por_hold};
        `SLCP_A_LAST: o_rdata <= {18'h0, shreg};
        default:      o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule // slcp_core

// File: test/slcp_core_asserts.sv
`timescale 1ns/100ps
`include "slcp_consts.vh"
// Port checker; registered outputs are allowed one settle cycle, two after a power-on request
module slcp_core_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic        i_por,
  input wire logic        i_rd,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] o_rdata,
  input wire logic [13:0] o_cfg,
  input wire logic [5:0]  o_lim_max,
  input wire logic [3:0]  o_limit_extension_factor,
  input wire logic        o_data_o,
  input wire logic        o_data_oe,
  input wire logic        o_rx_disable,
  input wire logic        o_off_cmd,
  input wire logic        o_in_reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Off command is a lone pulse
  sequence s_off;
    o_off_cmd ##1 !o_off_cmd;
  endsequence
  rst_cfg_a: assert property ($fell(i_srst) |-> o_cfg == `SLCP_CFG_DEF) else $error("cfg not default");
  rst_mark_a: assert property ($fell(i_srst) |-> o_in_reset) else $error("no marker mode");
  por_dflt_a: assert property (i_por |-> ##[1:2] (o_in_reset && o_cfg == `SLCP_CFG_DEF)) else $error("por");
  drive_low_a: assert property (o_data_o == 1'b0) else $error("line driven high");
  line_owner_a: assert property (o_data_oe |-> (o_rx_disable || o_in_reset))
    else $error("line pulled outside sequence or marker");
  factor_map_a: assert property ($stable(o_cfg) |-> o_limit_extension_factor == (4'h8 >> o_cfg[13:12]))
    else $error("factor");
  lim_map_a: assert property ($stable(o_cfg) |-> o_lim_max == ((o_cfg[5:0] < 6'h0c) ? 6'h18 : o_cfg[5:0]))
    else $error("limit");
  off_pulse_a: assert property (o_off_cmd |-> s_off) else $error("off pulse long");
  off_bit_a: assert property (o_off_cmd |-> ##[0:1] o_cfg[`SLCP_OFF_BIT]) else $error("off without bit");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata idle");
  rd_cfg_a: assert property ($past(i_rd && i_addr == `SLCP_A_CFG) |-> o_rdata == {18'h0, $past(o_cfg)})
    else $error("cfg read");
endmodule // slcp_core_asserts
bind slcp_core slcp_core_asserts u_slcp_core_asserts (.i_clk_sys, .i_srst, .i_por, .i_rd, .i_addr, .o_rdata,
  .o_cfg, .o_lim_max, .o_limit_extension_factor, .o_data_o, .o_data_oe, .o_rx_disable, .o_off_cmd, .o_in_reset);

// File: test/slcp_host_model.sv
`timescale 1ns/100ps
// Host on the shared line; pulls low only, the pull-up does the rest
module slcp_host_model #(
  parameter int TICK = 2
) (
  input  wire logic i_clk_sys,
  input  wire logic i_dev_low,
  output logic      o_host_low,
  output logic      o_ack,
  output logic      o_timeout
);
  initial begin
    o_host_low = 1'b0;
    o_ack = 1'b0;
    o_timeout = 1'b0;
  end
  // Bounded wait for a device drive level
  task wait_dev(input logic lvl, input int lim);
    int n;
    n = 0;
    while (i_dev_low !== lvl && n < lim) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= lim) o_timeout <= 1'b1;
  endtask
  // Start only while the device releases, so both never fight
  task start(input int t);
    wait_dev(1'b0, 64);
    o_host_low <= 1'b1;
    repeat (t * TICK) @(posedge i_clk_sys);
    o_host_low <= 1'b0;
  endtask
  // MSB first, locked to each sync pulse end
  task bits(input logic [13:0] w);
    int i;
    o_ack <= 1'b0;
    for (i = 13; i >= 0; i--) begin
      wait_dev(1'b1, 64 * TICK);
      wait_dev(1'b0, 16 * TICK);
      repeat (8 * TICK) @(posedge i_clk_sys);
      if (!w[i]) begin
        o_host_low <= 1'b1;
        repeat (4 * TICK) @(posedge i_clk_sys);
        o_host_low <= 1'b0;
      end
    end
    // Any device pull after the last bit is the acknowledge
    repeat (80 * TICK) begin
      @(posedge i_clk_sys);
      if (i_dev_low) o_ack <= 1'b1;
    end
  endtask
endmodule // slcp_host_model

// File: test/slcp_core_bench.sv
`timescale 1ns/100ps
`include "slcp_consts.vh"
module slcp_core_bench;
  logic        i_clk_sys = 1'b0, i_srst = 1'b1, i_por = 1'b1, i_rx_active = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [13:0] o_cfg;
  logic [5:0]  o_lim_max;
  logic [3:0]  o_limit_extension_factor;
  logic        o_data_oe, o_data_o, o_rx_disable, o_off_cmd, o_in_reset, host_low, ack, tmo, k, off_seen = 1'b0;
  int          failures = 0, samples_checked = 0, n;
  // Pull-up: high unless a party pulls low
  wire         i_data = !(o_data_oe | host_low);
  always #20 i_clk_sys = ~i_clk_sys;
  slcp_core #(.CLK_DIV(8'h02), .T_RST(16'h0004), .RM_HALF(16'h0008)) u_slcp_core (.i_clk_sys, .i_srst, .i_por,
    .i_rx_active, .i_data, .o_data_oe, .o_data_o, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_cfg, .o_lim_max,
    .o_limit_extension_factor, .o_rx_disable, .o_off_cmd, .o_in_reset);
  slcp_host_model #(.TICK(2)) u_slcp_host_model (.i_clk_sys, .i_dev_low(o_data_oe), .o_host_low(host_low),
    .o_ack(ack), .o_timeout(tmo));
  // Off pulse lasts one cycle, so latch it
  always @(posedge i_clk_sys) if (o_off_cmd) off_seen <= 1'b1;
  always @(posedge tmo) begin
    failures++;
    end_sim();
  end
  task end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge i_clk_sys);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    chk("rdata", e, o_rdata & m);
    cyc(1);
  endtask
  task prog(input int t, input logic [13:0] w);
    u_slcp_host_model.start(t);
    cyc(4);
    chk("rx_disable", 1, o_rx_disable);
    u_slcp_host_model.bits(w);
    cyc(20);
  endtask
  // Main sequence
  initial begin
    cyc(4);
    i_srst <= 1'b0;
    i_por <= 1'b0;
    cyc(2);
    chk("cfg", `SLCP_CFG_DEF, o_cfg);
    chk("in_reset", 1, o_in_reset);
    chk("factor", 8, o_limit_extension_factor);
    chk("lim", `SLCP_LIM_DEF, o_lim_max);
    cyc(10);
    rd(`SLCP_A_CFG, `SLCP_CFG_DEF, 32'hffffffff);
    rd(8'h0c, 0, 32'hffffffff);
    $display("test reset done");
    n = 0;
    repeat (64) begin
      k = o_data_oe;
      cyc(1);
      if (o_data_oe !== k) n++;
    end
    chk("marker", 4, n);
    u_slcp_host_model.start(100);
    cyc(100);
    chk("in_reset", 1, o_in_reset);
    chk("rx_disable", 0, o_rx_disable);
    wr(`SLCP_A_CFG, 32'h2c1d);
    rd(`SLCP_A_CFG, 32'h2c1d, 32'hffffffff);
    chk("factor", 2, o_limit_extension_factor);
    $display("test short start in reset done");
    prog(5700, 14'h1c19);
    chk("ack", 0, ack);
    chk("in_reset", 0, o_in_reset);
    chk("cfg", 14'h1c19, o_cfg);
    chk("factor", 4, o_limit_extension_factor);
    chk("lim", 6'h19, o_lim_max);
    $display("test long start done");
    i_rx_active <= 1'b1;
    prog(100, 14'h1c19);
    chk("ack", 1, ack);
    rd(`SLCP_A_STAT, 32'h10, 32'h10);
    prog(100, 14'h300a);
    chk("off", 1, off_seen);
    chk("factor", 1, o_limit_extension_factor);
    chk("lim", `SLCP_LIM_DEF, o_lim_max);
    rd(`SLCP_A_LAST, 32'h300a, 32'h3fff);
    $display("test short start done");
    i_por <= 1'b1;
    cyc(2);
    i_por <= 1'b0;
    cyc(2);
    chk("cfg", `SLCP_CFG_DEF, o_cfg);
    chk("in_reset", 1, o_in_reset);
    $display("test power-on done");
    end_sim();
  end
endmodule // slcp_core_bench
